/* rtl/dio_port.sv */
`timescale 1ns/100ps
`default_nettype none
module dio_port
#(
    parameter int ONLY_IN_BANK = 1
)
(
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             por,
    input  wire logic             wake_reset,
    input  wire dio_pkg::dio_req_s cpu_req,
    input  wire dio_pkg::dio_pins_s pin_in,
    input  wire dio_pkg::dio_pins_s alt_func,
    output logic                  cyc_start,
    output logic [7:0]            rd_data,
    output logic                  rd_valid,
    output dio_pkg::dio_pins_s    pin_out,
    output dio_pkg::dio_pins_s    pin_oe_n,
    output logic [7:0]            option_cfg,
    output logic                  pin_change_wake_flag
);
    import dio_pkg::*;

    if (ONLY_IN_BANK != 1 && ONLY_IN_BANK != 2)
    begin
        $error("ONLY_IN_BANK must be 1 or 2");
    end

    localparam logic [5:0] ONLY_IN_MASK = 6'h01 << ONLY_IN_BIT;
    localparam logic [5:0] MASK_B1 = (ONLY_IN_BANK == 1) ? ONLY_IN_MASK : 6'h00;
    localparam logic [5:0] MASK_B2 = (ONLY_IN_BANK == 2) ? ONLY_IN_MASK : 6'h00;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed
    {
        dio_phase_e phase;
        dio_op_e    op;
        logic [7:0] addr;
        logic [2:0] bitsel;
        logic [7:0] wdata;
        logic [7:0] samp;
        dio_pins_s  lat;
        dio_pins_s  dir;
        logic [7:0] option;
        logic       wake;
        logic [7:0] rd_data;
        logic       rd_valid;
        dio_pins_s  oe_n;
        logic       cyc;
    } dio_state_s;

    dio_state_s s;
    dio_state_s next_s;

    // register read view, bank pins only with alternate pins zero, status holds the wake flag
    function automatic logic [7:0] read_reg(input logic [7:0] a, input dio_pins_s p,
                                           input dio_pins_s alt, input logic wk);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            ADDR_BANK1:  v = {2'h0, p.bank1 & ~alt.bank1};
            ADDR_BANK2:  v = {2'h0, p.bank2 & ~alt.bank2};
            ADDR_STATUS: v[WAKE_BIT] = wk;
            default:     v = 8'h00;
        endcase
        return v;
    endfunction

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        logic [7:0] rmw;
        rmw = s.samp;
        next_s = s;
        next_s.rd_valid = 1'b0;
        case (s.phase)
            PH_Q1:
            begin
                next_s.phase = PH_Q2;
                next_s.op = OP_NONE;
                if (cpu_req.valid)
                begin
                    next_s.op = cpu_req.op;
                    next_s.addr = cpu_req.addr;
                    next_s.bitsel = cpu_req.bitsel;
                    next_s.wdata = cpu_req.wdata;
                    next_s.samp = read_reg(cpu_req.addr, pin_in, alt_func, s.wake);
                    if (cpu_req.op == OP_READ)
                    begin
                        next_s.rd_data = next_s.samp;
                        next_s.rd_valid = 1'b1;
                    end
                end
            end
            PH_Q2:
                next_s.phase = PH_Q3;
            PH_Q3:
                next_s.phase = PH_Q4;
            PH_Q4:
            begin
                next_s.phase = PH_Q1;
                rmw[s.bitsel] = (s.op == OP_BSET);
                case (s.op)
                    OP_WRITE:
                    begin
                        if (s.addr == ADDR_BANK1)
                            next_s.lat.bank1 = s.wdata[5:0];
                        if (s.addr == ADDR_BANK2)
                            next_s.lat.bank2 = s.wdata[5:0];
                    end
                    OP_BSET, OP_BCLR:
                    begin
                        if (s.addr == ADDR_BANK1)
                            next_s.lat.bank1 = rmw[5:0];
                        if (s.addr == ADDR_BANK2)
                            next_s.lat.bank2 = rmw[5:0];
                    end
                    OP_DIR:
                    begin
                        if (s.addr == ADDR_BANK1)
                            next_s.dir.bank1 = s.wdata[5:0];
                        if (s.addr == ADDR_BANK2)
                            next_s.dir.bank2 = s.wdata[5:0];
                    end
                    OP_OPTION:
                        next_s.option = s.wdata;
                    default:
                        next_s.option = s.option;
                endcase
                next_s.op = OP_NONE;
            end
            default:
                next_s.phase = PH_Q1;
        endcase
        if (reset)
        begin
            next_s.phase = PH_Q1;
            next_s.op = OP_NONE;
            next_s.dir.bank1 = DIR_RESET;
            next_s.dir.bank2 = DIR_RESET;
            next_s.option = OPT_RESET;
            next_s.wake = wake_reset & ~por;
            next_s.rd_data = 8'h00;
            next_s.rd_valid = 1'b0;
            if (por)
            begin
                next_s.lat.bank1 = LATCH_POR;
                next_s.lat.bank2 = LATCH_POR;
                next_s.addr = 8'h00;
                next_s.bitsel = 3'h0;
                next_s.wdata = 8'h00;
                next_s.samp = 8'h00;
            end
        end
        next_s.oe_n.bank1 = next_s.dir.bank1 | MASK_B1;
        next_s.oe_n.bank2 = next_s.dir.bank2 | MASK_B2;
        next_s.cyc = (next_s.phase == PH_Q1);
    end

    always_ff @(posedge core_clk)
    begin
        s <= next_s;
    end

    // ****************************************
    // outputs
    // ****************************************
    assign cyc_start            = s.cyc;
    assign rd_data              = s.rd_data;
    assign rd_valid             = s.rd_valid;
    assign pin_out              = s.lat;
    assign pin_oe_n             = s.oe_n;
    assign option_cfg           = s.option;
    assign pin_change_wake_flag = s.wake;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    chk_dir_reset: assert property ($fell(reset) |-> s.dir == {DIR_RESET, DIR_RESET})
        else $error("direction not all ones after reset");
    chk_opt_reset: assert property ($fell(reset) |-> option_cfg == OPT_RESET)
        else $error("option not all ones after reset");
    chk_wake_cause: assert property ($fell(reset)
        |-> pin_change_wake_flag == ($past(wake_reset) && !$past(por)))
        else $error("wake flag does not match reset cause");
    chk_read_pins: assert property (cyc_start && cpu_req.valid && cpu_req.op == OP_READ
        && cpu_req.addr == ADDR_BANK1 |=> rd_valid
        && rd_data == {2'h0, $past(pin_in.bank1) & ~$past(alt_func.bank1)})
        else $error("bank read did not return sampled pins");
    chk_upper_zero: assert property (rd_valid && s.addr != ADDR_STATUS |-> rd_data[7:6] == 2'h0)
        else $error("unimplemented bits read nonzero");
    chk_write_late: assert property (cyc_start && cpu_req.valid && cpu_req.op == OP_WRITE
        && cpu_req.addr == ADDR_BANK2 |=> $stable(pin_out.bank2) [*3]
        ##1 pin_out.bank2 == $past(cpu_req.wdata[5:0], 4))
        else $error("bank write not applied at end of cycle");
    chk_rmw_bank: assert property (cyc_start && cpu_req.valid && cpu_req.op == OP_BSET
        && cpu_req.addr == ADDR_BANK1 && cpu_req.bitsel < 3'h6 |-> ##4
        pin_out.bank1 == (($past(pin_in.bank1, 4) & ~$past(alt_func.bank1, 4))
        | (6'h01 << $past(cpu_req.bitsel, 4))))
        else $error("bit set did not rewrite the bank from pins");
    chk_only_input: assert property ((pin_oe_n.bank1 & MASK_B1) == MASK_B1
        && (pin_oe_n.bank2 & MASK_B2) == MASK_B2)
        else $error("input-only pin driven");
    chk_oe_follow: assert property (cyc_start && cpu_req.valid && cpu_req.op == OP_DIR
        && cpu_req.addr == ADDR_BANK2 |-> ##4
        pin_oe_n.bank2 == ($past(cpu_req.wdata[5:0], 4) | MASK_B2))
        else $error("enable does not follow direction");
    chk_phase_walk: assert property (cyc_start |=> !cyc_start [*3] ##1 cyc_start)
        else $error("instruction cycle is not four clocks");

    cov_read: cover property (rd_valid && s.addr == ADDR_BANK2);
    cov_rmw_clr: cover property (s.phase == PH_Q4 && s.op == OP_BCLR);
    cov_dir_write: cover property (s.phase == PH_Q4 && s.op == OP_DIR);
    cov_wake: cover property (pin_change_wake_flag);
endmodule
`default_nettype wire

/* rtl/dio_pkg.sv */
// Behaviour
// - pin-bank registers hold six bits; bits seven and six read zero.
// - latches cleared on power-on, kept otherwise; direction and option reset to ones.
// - wake flag set when reset came from pin-change wake, else cleared.
// - bit set or clear reads whole bank, modifies bit, writes all latches.
// - input pins get their sampled level copied into their latch on those.
// - a latch write lands at the end of the executing instruction cycle.
// - a bank read samples the pins at the start of the instruction cycle.
// - direction one floats the driver; direction zero drives the pin from its latch.
// - a bank read returns pin levels, never the latch contents.
// - bit three of the input-only bank never has its driver enabled.
// - pins given to an alternate function read as zero.
`default_nettype none
package dio_pkg;
    localparam int         BANK_W      = 6;
    localparam logic [7:0] ADDR_STATUS = 8'h03;
    localparam logic [7:0] ADDR_BANK1  = 8'h06;
    localparam logic [7:0] ADDR_BANK2  = 8'h07;
    localparam int         WAKE_BIT    = 7;
    localparam int         ONLY_IN_BIT = 3;
    localparam logic [5:0] DIR_RESET   = 6'h3f;
    localparam logic [7:0] OPT_RESET   = 8'hff;
    localparam logic [5:0] LATCH_POR   = 6'h00;
    localparam int         OPT_WAKE_DIS_BIT   = 7;
    localparam int         OPT_PULLUP_DIS_BIT = 6;

    // ****************************************
    // instruction-cycle phases and operations
    // ****************************************
    typedef enum logic [1:0]
    {
        PH_Q1 = 2'h0,
        PH_Q2 = 2'h1,
        PH_Q3 = 2'h3,
        PH_Q4 = 2'h2
    } dio_phase_e;

    typedef enum logic [2:0]
    {
        OP_NONE   = 3'h0,
        OP_READ   = 3'h1,
        OP_WRITE  = 3'h2,
        OP_BSET   = 3'h3,
        OP_BCLR   = 3'h4,
        OP_DIR    = 3'h5,
        OP_OPTION = 3'h6
    } dio_op_e;

    typedef struct packed
    {
        logic       valid;
        dio_op_e    op;
        logic [7:0] addr;
        logic [2:0] bitsel;
        logic [7:0] wdata;
    } dio_req_s;

    typedef struct packed
    {
        logic [5:0] bank1;
        logic [5:0] bank2;
    } dio_pins_s;
endpackage
`default_nettype wire

/* dv/dio_pin_model.sv */
`timescale 1ns/100ps
`default_nettype none
module dio_pin_model
(
    input  wire dio_pkg::dio_pins_s pin_out,
    input  wire dio_pkg::dio_pins_s pin_oe_n,
    input  wire dio_pkg::dio_pins_s ext_en,
    input  wire dio_pkg::dio_pins_s ext_val,
    output var  dio_pkg::dio_pins_s pin_in
);
    import dio_pkg::*;
    // ****************************************
    // wire level per pin
    // ****************************************
    always_comb
    begin
        for (int i = 0; i < 12; i++)
        begin
            if (ext_en[i])
                pin_in[i] = ext_val[i];
            else if (!pin_oe_n[i])
                pin_in[i] = pin_out[i];
            else
                pin_in[i] = ~pin_out[i];
        end
    end
endmodule
`default_nettype wire

/* dv/test_dual_io_port_latches.sv */
`timescale 1ns/100ps
`default_nettype none
module test_dual_io_port_latches;
    import dio_pkg::*;
    logic       core_clk, reset, por, wake_reset, cyc_start, rd_valid, pin_change_wake_flag;
    dio_req_s   cpu_req;
    dio_pins_s  pin_in, alt_func, pin_out, pin_oe_n, ext_en, ext_val;
    logic [7:0] rd_data, option_cfg;
    int         n_errors, n_tests;

    dio_port dut_u (.core_clk(core_clk), .reset(reset), .por(por), .wake_reset(wake_reset),
        .cpu_req(cpu_req), .pin_in(pin_in), .alt_func(alt_func), .cyc_start(cyc_start),
        .rd_data(rd_data), .rd_valid(rd_valid), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .option_cfg(option_cfg), .pin_change_wake_flag(pin_change_wake_flag));
    dio_pin_model pins_u (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_en(ext_en),
        .ext_val(ext_val), .pin_in(pin_in));

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // ****************************************
    // check, result and access tasks
    // ****************************************
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic op(input dio_op_e o, input logic [7:0] a, input logic [2:0] b,
                      input logic [7:0] d);
        int k;
        for (k = 0; k < 8 && cyc_start !== 1'b1; k++)
            @(negedge core_clk);
        if (k == 8)
        begin
            n_errors++;
            results();
        end
        cpu_req = '{1'b1, o, a, b, d};
        @(negedge core_clk);
        cpu_req.valid = 1'b0;
    endtask

    task automatic wr(input dio_op_e o, input logic [7:0] a, input logic [2:0] b,
                      input logic [7:0] d, input logic [5:0] exp, input logic two);
        logic [5:0] old;
        op(o, a, b, d);
        old = two ? pin_out.bank2 : pin_out.bank1;
        repeat (2) @(negedge core_clk);
        chk("latch_early", {6'h0, old}, {6'h0, two ? pin_out.bank2 : pin_out.bank1});
        @(negedge core_clk);
        chk("latch", {6'h0, exp}, {6'h0, two ? pin_out.bank2 : pin_out.bank1});
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        op(OP_READ, a, 3'h0, 8'h00);
        chk("rd_valid", 12'h001, {11'h0, rd_valid});
        chk("rd_data", {4'h0, exp}, {4'h0, rd_data});
        ext_val.bank1 = ~ext_val.bank1;
        @(negedge core_clk);
        chk("rd_hold", {4'h0, exp}, {4'h0, rd_data});
        chk("rd_pulse", 12'h000, {11'h0, rd_valid});
        ext_val.bank1 = ~ext_val.bank1;
    endtask

    task automatic rst(input logic p, input logic w);
        reset = 1'b1;
        por = p;
        wake_reset = w;
        repeat (2) @(negedge core_clk);
        reset = 1'b0;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        n_errors = 0;
        n_tests = 0;
        reset = 1'b1;
        por = 1'b1;
        wake_reset = 1'b0;
        cpu_req = '0;
        alt_func = '0;
        ext_en = '{6'h09, 6'h38};
        ext_val = '{6'h08, 6'h28};
        repeat (20) @(negedge core_clk);
        chk("oe_n", 12'hfff, pin_oe_n);
        chk("option", 12'h0ff, {4'h0, option_cfg});
        chk("latch_por", 12'h000, pin_out);
        chk("wake_por", 12'h000, {11'h0, pin_change_wake_flag});
        reset = 1'b0;
        $display("test power-on reset done");
        op(OP_OPTION, 8'h00, 3'h0, 8'h3c);
        repeat (3) @(negedge core_clk);
        chk("option", 12'h03c, {4'h0, option_cfg});
        wr(OP_BSET, ADDR_BANK1, 3'h4, 8'h00, 6'h3e, 1'b0);
        wr(OP_WRITE, ADDR_BANK1, 3'h0, 8'hff, 6'h3f, 1'b0);
        op(OP_DIR, ADDR_BANK1, 3'h0, 8'h00);
        repeat (3) @(negedge core_clk);
        chk("oe_n", {6'h08, 6'h3f}, pin_oe_n);
        op(OP_NONE, 8'h00, 3'h0, 8'h00);
        rd(ADDR_BANK1, 8'h3e);
        $display("test bank one done");
        wr(OP_WRITE, ADDR_BANK2, 3'h0, 8'h05, 6'h05, 1'b1);
        op(OP_DIR, ADDR_BANK2, 3'h0, 8'h38);
        wr(OP_BSET, ADDR_BANK2, 3'h1, 8'h00, 6'h2f, 1'b1);
        alt_func.bank2 = 6'h20;
        wr(OP_BCLR, ADDR_BANK2, 3'h1, 8'h00, 6'h0d, 1'b1);
        rd(ADDR_BANK2, 8'h0d);
        rd(8'h05, 8'h00);
        rd(ADDR_STATUS, 8'h00);
        $display("test bank two done");
        rst(1'b0, 1'b1);
        chk("latch_kept", {6'h3f, 6'h0d}, pin_out);
        chk("oe_n", 12'hfff, pin_oe_n);
        chk("option", 12'h0ff, {4'h0, option_cfg});
        rd(ADDR_STATUS, 8'h80);
        rst(1'b0, 1'b0);
        chk("wake", 12'h000, {11'h0, pin_change_wake_flag});
        $display("test warm resets done");
        results();
    end
endmodule
`default_nettype wire
